// ---- include/backlight_pkg.sv ----
/*
 * Shared constants for the backlight dimming configuration slice: register offsets,
 * reset values, write masks, field positions, serial-bus states and PWM sampler limits.
 * Assumes a single 250 MHz system clock and an 8-bit register pointer on the serial bus.
 */
`default_nettype none

package backlight_pkg;

    // The bus address is arbitrary; it only has to match what the host is built with.
    localparam logic [6:0] DEV_ADDR = 7'h36;

    localparam logic [7:0] OFS_BOOST = 8'h02;
    localparam logic [7:0] OFS_BRIGHT_A = 8'h03;
    localparam logic [7:0] OFS_BRIGHT_B = 8'h04;
    localparam logic [7:0] OFS_CURRENT_A = 8'h05;
    localparam logic [7:0] OFS_CURRENT_B = 8'h06;
    localparam logic [7:0] OFS_RAMP = 8'h07;

    localparam logic [7:0] RST_BOOST = 8'h38;
    localparam logic [7:0] RST_BRIGHT = 8'h00;
    localparam logic [7:0] RST_CURRENT = 8'h1F;
    localparam logic [7:0] RST_RAMP = 8'h00;

    // Writable bits per register; every other bit is read-only and reads zero.
    localparam logic [7:0] MASK_BOOST = 8'h7F;
    localparam logic [7:0] MASK_CURRENT_A = 8'hDF;
    localparam logic [7:0] MASK_CURRENT_B = 8'h1F;
    localparam logic [7:0] MASK_RAMP = 8'h3F;

    localparam int BOOST_FREQ_BIT = 0;
    localparam int CUR_HYST_BIT = 7;
    localparam int CUR_LB_BIT = 6;
    localparam int CUR_CODE_MSB = 4;
    localparam int RAMP_START_MSB = 5;
    localparam int RAMP_START_LSB = 3;
    localparam int RAMP_SHUT_MSB = 2;
    localparam logic [2:0] RAMP_SHORT_CODE = 3'h0;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    localparam int PWM_CODE_W = 8;
    localparam logic [PWM_CODE_W-1:0] HYST_STEPS_CLEAR = 8'h03;
    localparam logic [PWM_CODE_W-1:0] HYST_STEPS_SET = 8'h02;
    localparam logic [PWM_CODE_W-1:0] LB_ZERO_MAX = 8'h01;
    localparam logic [PWM_CODE_W-1:0] LB_FLOOR_MAX = 8'h06;
    localparam logic [PWM_CODE_W-1:0] LB_FLOOR_CODE = 8'h06;
    localparam logic [PWM_CODE_W-1:0] LB_ZERO_CODE = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR = 3'h2,
        ST_WR_ACK = 3'h6,
        ST_RD = 3'h7,
        ST_RD_ACK = 3'h5
    } bus_state_t;

endpackage

`default_nettype wire

// ---- include/pwm_sampler_if.sv ----
/*
 * Carrier between the register bank and the PWM input sampler.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface pwm_sampler_if;
    logic hyst_two;
    logic lower_bound_en;
    logic raw_valid;
    logic [backlight_pkg::PWM_CODE_W-1:0] raw_code;
    logic [backlight_pkg::PWM_CODE_W-1:0] out_code;

    modport cfg (output hyst_two, output lower_bound_en, output raw_valid, output raw_code, input out_code);
    modport core (input hyst_two, input lower_bound_en, input raw_valid, input raw_code, output out_code);
endinterface

`default_nettype wire

// ---- hw/pwm_sampler.sv ----
/*
 * PWM input sampler: filters the sampled equivalent code with a step hysteresis and
 * applies the optional lower-bound mapping. Assumes raw codes arrive on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pwm_sampler (
    input wire logic clk_sys,
    input wire logic rstn,
    pwm_sampler_if.core smp
);
    localparam int W = backlight_pkg::PWM_CODE_W;

    logic [W-1:0] held_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] step;
    logic [W-1:0] threshold;
    logic [W-1:0] held_next;
    logic [W-1:0] out_next;

    assign step = (smp.raw_code > held_reg) ? smp.raw_code - held_reg : held_reg - smp.raw_code;
    assign threshold = smp.hyst_two ? backlight_pkg::HYST_STEPS_SET : backlight_pkg::HYST_STEPS_CLEAR;
    assign held_next = (smp.raw_valid && step >= threshold) ? smp.raw_code : held_reg;
    assign out_next = smp.lower_bound_en ? held_next :
        (held_next <= backlight_pkg::LB_ZERO_MAX) ? backlight_pkg::LB_ZERO_CODE :
        (held_next <= backlight_pkg::LB_FLOOR_MAX) ? backlight_pkg::LB_FLOOR_CODE : held_next;
    assign smp.out_code = out_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            held_reg <= '0;
            out_reg <= '0;
        end else begin
            held_reg <= held_next;
            out_reg <= out_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_hyst_step;
        $changed(held_reg) |-> $past(smp.raw_valid) && ($past(step) >= $past(threshold));
    endproperty
    a_hyst_step: assert property (p_hyst_step) else $error("Sampler moved on a step below the hysteresis.");

    property p_floor_map;
        !smp.lower_bound_en && held_next >= 8'h02 && held_next <= 8'h06 |=> out_reg == 8'h06;
    endproperty
    a_floor_map: assert property (p_floor_map) else $error("Sampler did not floor codes 2 to 6 at 6.");

    property p_zero_map;
        !smp.lower_bound_en && held_next <= 8'h01 |=> out_reg == 8'h00;
    endproperty
    a_zero_map: assert property (p_zero_map) else $error("Sampler did not map codes 0 and 1 to 0.");

    property p_free_low;
        smp.lower_bound_en |=> out_reg == $past(held_next);
    endproperty
    a_free_low: assert property (p_free_low) else $error("Sampler output does not follow the filtered code.");

    c_low_code: cover property (smp.lower_bound_en && out_reg < 8'h06 && out_reg != 8'h00);
endmodule

`default_nettype wire

// ---- hw/backlight_dimming_config_regs.sv ----
/*
 * Register slice of a dual-bank backlight driver reached over an I2C-compatible serial
 * bus: boost frequency select, bank brightness, full-scale current, PWM sampler controls
 * and on/off ramp times. Assumes an open-drain bus with external pull-ups resolved by
 * the surroundings, and a sleep status level from the control logic on the same clock.
 */
// Summary of operation
// - Boost register bit 0 picks 500 kHz when zero and 1 MHz when one.
// - Bank A brightness is an 8-bit value applied to every bank A output.
// - Bank B brightness is an 8-bit value applied to every bank B output.
// - While sleep status is one, writes to both brightness registers are discarded.
// - Current A bit 7 sets the sampler hysteresis to 3 code steps when clear and 2 when set.
// - With lower-bound bit 6 clear, sampled codes 2 to 6 give 6 and codes 0 to 1 give 0.
// - With lower-bound bit 6 set, the sampler follows the filtered code below 6 as well.
// - Each bank keeps a 5-bit full-scale current code in bits 4 to 0 of its current register.
// - Both current registers read 1Fh after reset.
// - Brightness registers reset to 00h and the boost register to 38h.
// - The ramp register holds startup time in bits 5 to 3, shutdown in 2 to 0, bits 7 and 6 read-only.
// - A ramp code of zero selects the short, near-immediate transition.
`timescale 1ns/1ps
`default_nettype none

module backlight_dimming_config_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sleep_status,
    input wire logic [backlight_pkg::PWM_CODE_W-1:0] pwm_code,
    input wire logic pwm_code_valid,
    output logic boost_freq_select,
    output logic [5:0] boost_aux_settings,
    output logic [7:0] bank_a_brightness,
    output logic [7:0] bank_b_brightness,
    output logic [4:0] bank_a_full_scale,
    output logic [4:0] bank_b_full_scale,
    output logic [2:0] startup_ramp_code,
    output logic [2:0] shutdown_ramp_code,
    output logic startup_ramp_short,
    output logic shutdown_ramp_short,
    output logic [backlight_pkg::PWM_CODE_W-1:0] pwm_sampled_code
);
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    backlight_pkg::bus_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg, ptr_reg;
    logic rw_reg, first_reg, oe_reg, mack_reg;
    logic [7:0] boost_reg, bright_a_reg, bright_b_reg, cur_a_reg, cur_b_reg, ramp_reg;

    // Both bus pins pass three flip-flops; only the second stage and later are decoded.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_in;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, byte_done, wr_en;
    assign scl_rise = scl_sync_reg && !scl_prev_reg;
    assign scl_fall = !scl_sync_reg && scl_prev_reg;
    assign start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
    assign stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
    assign byte_done = scl_fall && bit_cnt_reg == backlight_pkg::BITS_PER_BYTE;
    assign wr_en = state_reg == backlight_pkg::ST_WR && byte_done && !first_reg;

    logic wr_boost, wr_bright_a, wr_bright_b, wr_cur_a, wr_cur_b, wr_ramp;
    assign wr_boost = wr_en && ptr_reg == backlight_pkg::OFS_BOOST;
    assign wr_bright_a = wr_en && ptr_reg == backlight_pkg::OFS_BRIGHT_A && !sleep_status;
    assign wr_bright_b = wr_en && ptr_reg == backlight_pkg::OFS_BRIGHT_B && !sleep_status;
    assign wr_cur_a = wr_en && ptr_reg == backlight_pkg::OFS_CURRENT_A;
    assign wr_cur_b = wr_en && ptr_reg == backlight_pkg::OFS_CURRENT_B;
    assign wr_ramp = wr_en && ptr_reg == backlight_pkg::OFS_RAMP;

    // Read-only bits are masked off on the way in, so they always read zero.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            boost_reg <= backlight_pkg::RST_BOOST;
            bright_a_reg <= backlight_pkg::RST_BRIGHT;
            bright_b_reg <= backlight_pkg::RST_BRIGHT;
            cur_a_reg <= backlight_pkg::RST_CURRENT;
            cur_b_reg <= backlight_pkg::RST_CURRENT;
            ramp_reg <= backlight_pkg::RST_RAMP;
        end else begin
            if (wr_boost) boost_reg <= shift_reg & backlight_pkg::MASK_BOOST;
            if (wr_bright_a) bright_a_reg <= shift_reg;
            if (wr_bright_b) bright_b_reg <= shift_reg;
            if (wr_cur_a) cur_a_reg <= shift_reg & backlight_pkg::MASK_CURRENT_A;
            if (wr_cur_b) cur_b_reg <= shift_reg & backlight_pkg::MASK_CURRENT_B;
            if (wr_ramp) ramp_reg <= shift_reg & backlight_pkg::MASK_RAMP;
        end
    end

    logic [7:0] rd_data;
    assign rd_data = (ptr_reg == backlight_pkg::OFS_BOOST) ? boost_reg :
        (ptr_reg == backlight_pkg::OFS_BRIGHT_A) ? bright_a_reg :
        (ptr_reg == backlight_pkg::OFS_BRIGHT_B) ? bright_b_reg :
        (ptr_reg == backlight_pkg::OFS_CURRENT_A) ? cur_a_reg :
        (ptr_reg == backlight_pkg::OFS_CURRENT_B) ? cur_b_reg :
        (ptr_reg == backlight_pkg::OFS_RAMP) ? ramp_reg : 8'h00;

    // Serial slave: address byte, pointer byte, then data bytes with auto-increment.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= backlight_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b1;
            oe_reg <= 1'b0;
            mack_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= backlight_pkg::ST_ADDR;
            bit_cnt_reg <= 4'h0;
            first_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= backlight_pkg::ST_IDLE;
            oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                backlight_pkg::ST_ADDR, backlight_pkg::ST_WR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_sync_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done && state_reg == backlight_pkg::ST_ADDR) begin
                        if (shift_reg[7:1] == backlight_pkg::DEV_ADDR) begin
                            rw_reg <= shift_reg[0];
                            oe_reg <= 1'b1;
                            state_reg <= backlight_pkg::ST_ADDR_ACK;
                        end else begin
                            state_reg <= backlight_pkg::ST_IDLE;
                        end
                    end else if (byte_done) begin
                        if (first_reg) begin
                            ptr_reg <= shift_reg;
                            first_reg <= 1'b0;
                        end else begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        oe_reg <= 1'b1;
                        state_reg <= backlight_pkg::ST_WR_ACK;
                    end
                end
                backlight_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            tx_reg <= rd_data;
                            oe_reg <= !rd_data[7];
                            state_reg <= backlight_pkg::ST_RD;
                        end else begin
                            oe_reg <= 1'b0;
                            state_reg <= backlight_pkg::ST_WR;
                        end
                    end
                end
                backlight_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        oe_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= backlight_pkg::ST_WR;
                    end
                end
                backlight_pkg::ST_RD: begin
                    if (scl_fall && bit_cnt_reg == backlight_pkg::LAST_TX_BIT) begin
                        oe_reg <= 1'b0;
                        ptr_reg <= ptr_reg + 8'h01;
                        state_reg <= backlight_pkg::ST_RD_ACK;
                    end else if (scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        oe_reg <= !tx_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                backlight_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        mack_reg <= !sda_sync_reg;
                    end else if (scl_fall && mack_reg) begin
                        tx_reg <= rd_data;
                        oe_reg <= !rd_data[7];
                        bit_cnt_reg <= 4'h0;
                        state_reg <= backlight_pkg::ST_RD;
                    end else if (scl_fall) begin
                        state_reg <= backlight_pkg::ST_IDLE;
                    end
                end
                default: begin
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;

    assign boost_freq_select = boost_reg[backlight_pkg::BOOST_FREQ_BIT];
    assign boost_aux_settings = boost_reg[6:1];
    assign bank_a_brightness = bright_a_reg;
    assign bank_b_brightness = bright_b_reg;
    assign bank_a_full_scale = cur_a_reg[backlight_pkg::CUR_CODE_MSB:0];
    assign bank_b_full_scale = cur_b_reg[backlight_pkg::CUR_CODE_MSB:0];
    assign startup_ramp_code = ramp_reg[backlight_pkg::RAMP_START_MSB:backlight_pkg::RAMP_START_LSB];
    assign shutdown_ramp_code = ramp_reg[backlight_pkg::RAMP_SHUT_MSB:0];
    assign startup_ramp_short = startup_ramp_code == backlight_pkg::RAMP_SHORT_CODE;
    assign shutdown_ramp_short = shutdown_ramp_code == backlight_pkg::RAMP_SHORT_CODE;

    pwm_sampler_if smp_bus ();
    assign smp_bus.hyst_two = cur_a_reg[backlight_pkg::CUR_HYST_BIT];
    assign smp_bus.lower_bound_en = cur_a_reg[backlight_pkg::CUR_LB_BIT];
    assign smp_bus.raw_code = pwm_code;
    assign smp_bus.raw_valid = pwm_code_valid;
    assign pwm_sampled_code = smp_bus.out_code;

    pwm_sampler sampler (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .smp(smp_bus.core)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_boost_freq;
        wr_en && ptr_reg == 8'h02 |=> boost_freq_select == $past(shift_reg[0]) && !boost_reg[7];
    endproperty
    a_boost_freq: assert property (p_boost_freq) else $error("Boost frequency select not taken from bit 0.");

    property p_bright_a;
        wr_en && ptr_reg == 8'h03 && !sleep_status |=> bank_a_brightness == $past(shift_reg);
    endproperty
    a_bright_a: assert property (p_bright_a) else $error("Bank A brightness write not applied.");

    property p_bright_b;
        wr_en && ptr_reg == 8'h04 && !sleep_status |=> bank_b_brightness == $past(shift_reg);
    endproperty
    a_bright_b: assert property (p_bright_b) else $error("Bank B brightness write not applied.");

    property p_sleep_hold;
        sleep_status |=> $stable(bright_a_reg) && $stable(bright_b_reg);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("Brightness changed while asleep.");

    property p_current_b;
        wr_en && ptr_reg == 8'h06 |=> bank_b_full_scale == $past(shift_reg[4:0]) && cur_b_reg[7:5] == 3'h0;
    endproperty
    a_current_b: assert property (p_current_b) else $error("Bank B current code not stored in bits 4 to 0.");

    property p_reset_vals;
        $rose(rstn) |-> cur_a_reg == 8'h1F && cur_b_reg == 8'h1F && boost_reg == 8'h38 && bright_a_reg == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("Register reset value wrong.");

    property p_ramp_fields;
        wr_en && ptr_reg == 8'h07 |=> startup_ramp_code == $past(shift_reg[5:3]) && ramp_reg[7:6] == 2'h0;
    endproperty
    a_ramp_fields: assert property (p_ramp_fields) else $error("Ramp fields misplaced or bits 7 and 6 written.");

    property p_ramp_short;
        wr_en && ptr_reg == 8'h07 && shift_reg[2:0] == 3'h0 |=> shutdown_ramp_short;
    endproperty
    a_ramp_short: assert property (p_ramp_short) else $error("Code zero did not select the short ramp.");

    property p_reserved_zero;
        wr_en && ptr_reg == 8'h05 |=> cur_a_reg[5] == 1'b0 && cur_a_reg[7] == $past(shift_reg[7]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved current A bit 5 not zero.");

    c_sleep_write: cover property (sleep_status && wr_en && ptr_reg == 8'h03);
    c_read_byte: cover property (state_reg == backlight_pkg::ST_RD_ACK && mack_reg);
    c_write_ack: cover property (state_reg == backlight_pkg::ST_WR_ACK && !first_reg);
endmodule

`default_nettype wire

// ---- tb/i2c_host_model.sv ----
/*
 * Host side of the serial bus: a bus master with register write and read tasks.
 * Assumes the bench resolves the open-drain data line and feeds the level back.
 */
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic half();
        repeat (5) @(negedge clk_sys);
    endtask

    // Data moves two cycles after the clock falls, so it never changes while the clock is high.
    task automatic put_bit(input logic b, output logic got);
        repeat (2) @(negedge clk_sys);
        sda_pull = !b;
        half();
        scl = 1'b1;
        half();
        got = sda_line;
        scl = 1'b0;
    endtask

    task automatic start();
        repeat (2) @(negedge clk_sys);
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        repeat (2) @(negedge clk_sys);
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b0;
        half();
    endtask

    task automatic send_byte(input logic [7:0] v, output logic nack);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(v[i], g);
        put_bit(1'b1, nack);
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic n0, n1, n2;
        start();
        send_byte({a, 1'b0}, n0);
        send_byte(p, n1);
        send_byte(d, n2);
        stop();
        ok = !(n0 || n1 || n2);
    endtask

    task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
        logic n;
        start();
        send_byte({backlight_pkg::DEV_ADDR, 1'b0}, n);
        send_byte(p, n);
        start();
        send_byte({backlight_pkg::DEV_ADDR, 1'b1}, n);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(1'b1, n);
        stop();
    endtask
endmodule

`default_nettype wire

// ---- tb/backlight_dimming_config_regs_tb_top.sv ----
/*
 * Self-checking bench for the backlight register slice: bus writes and reads, sleep
 * lockout, wrong address and the PWM sampler. Assumes the host model in this folder.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: value %h, expected %h", $time, g, e); end end

module backlight_dimming_config_regs_tb_top;
    logic clk_sys = 1'b0, rstn = 1'b0, sleep_status = 1'b0, pwm_code_valid = 1'b0;
    logic [7:0] pwm_code = 8'h00, held = 8'h00, d;
    logic [7:0] exp_reg [9] = '{8'h00, 8'h00, 8'h38, 8'h00, 8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00};
    logic scl, sda_pull, sda_out, sda_oe, boost_freq_select, startup_ramp_short, shutdown_ramp_short, ok;
    logic [5:0] boost_aux_settings;
    logic [7:0] bank_a_brightness, bank_b_brightness, pwm_sampled_code;
    logic [4:0] bank_a_full_scale, bank_b_full_scale;
    logic [2:0] startup_ramp_code, shutdown_ramp_code;
    logic [31:0] v;
    int n_errors = 0, tests_run = 0, seed = 54095;
    wire sda_line = !(sda_pull || (sda_oe && !sda_out));

    initial forever #2 clk_sys = !clk_sys;

    i2c_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
    backlight_dimming_config_regs uut (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .sleep_status(sleep_status), .pwm_code(pwm_code),
        .pwm_code_valid(pwm_code_valid), .boost_freq_select(boost_freq_select),
        .boost_aux_settings(boost_aux_settings), .bank_a_brightness(bank_a_brightness),
        .bank_b_brightness(bank_b_brightness), .bank_a_full_scale(bank_a_full_scale),
        .bank_b_full_scale(bank_b_full_scale), .startup_ramp_code(startup_ramp_code),
        .shutdown_ramp_code(shutdown_ramp_code), .startup_ramp_short(startup_ramp_short),
        .shutdown_ramp_short(shutdown_ramp_short), .pwm_sampled_code(pwm_sampled_code));

    function automatic logic [7:0] mask_of(input logic [2:0] p);
        case (p)
            3'h2: return backlight_pkg::MASK_BOOST;
            3'h5: return backlight_pkg::MASK_CURRENT_A;
            3'h6: return backlight_pkg::MASK_CURRENT_B;
            3'h7: return backlight_pkg::MASK_RAMP;
            default: return 8'hFF;
        endcase
    endfunction

    // Sampler reference: the held code moves only on a large enough step.
    function automatic void pwm_step(input logic [7:0] c, input logic h2);
        logic [7:0] diff;
        diff = (c > held) ? c - held : held - c;
        if (diff >= (h2 ? 8'h02 : 8'h03)) held = c;
    endfunction

    function automatic logic [7:0] pwm_out(input logic lb);
        if (lb) return held;
        return (held <= 8'h01) ? 8'h00 : ((held <= 8'h06) ? 8'h06 : held);
    endfunction

    task automatic wr(input logic [7:0] p, input logic [7:0] dat);
        logic k;
        host.write_reg(backlight_pkg::DEV_ADDR, p, dat, k);
        `CHECK(k, 1'b1);
        if (!(sleep_status && (p == 8'h03 || p == 8'h04))) exp_reg[p[2:0]] = dat & mask_of(p[2:0]);
    endtask

    task automatic check_all();
        logic [7:0] r;
        for (int p = 2; p <= 8; p++) begin
            host.read_reg(8'(p), r);
            `CHECK(r, exp_reg[p]);
        end
        `CHECK({boost_aux_settings, boost_freq_select}, exp_reg[2][6:0]);
        `CHECK(bank_a_brightness, exp_reg[3]);
        `CHECK(bank_b_brightness, exp_reg[4]);
        `CHECK({bank_a_full_scale, bank_b_full_scale}, {exp_reg[5][4:0], exp_reg[6][4:0]});
        `CHECK({startup_ramp_code, shutdown_ramp_code}, exp_reg[7][5:0]);
        `CHECK({startup_ramp_short, shutdown_ramp_short}, {exp_reg[7][5:3] == 3'h0, exp_reg[7][2:0] == 3'h0});
    endtask

    task automatic end_of_test();
        $display("Comparisons: %0d, mismatches: %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHECK({bank_a_full_scale, bank_b_full_scale}, 10'h3FF);
        `CHECK({bank_a_brightness, bank_b_brightness, boost_aux_settings, boost_freq_select}, 23'h38);
        check_all();
        for (int r = 0; r < 2; r++) begin
            for (int p = 2; p <= 7; p++) begin
                v = $random(seed);
                d = (r == 0) ? 8'hFF : v[7:0];
                if ((p == 3 || p == 4) && d < 8'h04) d = 8'h04;
                wr(8'(p), d);
            end
            check_all();
        end
        wr(8'h07, 8'hC0);
        check_all();
        sleep_status = 1'b1;
        wr(8'h03, 8'h5A);
        wr(8'h04, 8'hA5);
        `CHECK({bank_a_brightness, bank_b_brightness}, {exp_reg[3], exp_reg[4]});
        check_all();
        sleep_status = 1'b0;
        host.write_reg(backlight_pkg::DEV_ADDR ^ 7'h01, 8'h03, 8'h77, ok);
        `CHECK({ok, bank_a_brightness}, {1'b0, exp_reg[3]});
        for (int c = 0; c < 4; c++) begin
            wr(8'h05, {c[1], c[0], 6'h1F});
            repeat (2) @(negedge clk_sys);
            `CHECK(pwm_sampled_code, pwm_out(c[0]));
            repeat (12) begin
                v = $random(seed);
                pwm_code = 8'(v[2:0]) + 8'(v[5:3]);
                pwm_code_valid = 1'b1;
                @(negedge clk_sys);
                pwm_code_valid = 1'b0;
                pwm_step(pwm_code, c[1]);
                repeat (2) @(negedge clk_sys);
                `CHECK(pwm_sampled_code, pwm_out(c[0]));
            end
        end
        end_of_test();
    end
endmodule

`default_nettype wire
